// ### bk1_sfr_bank.sv
// Bank-one special function register map behind an APB slave port.
// Behaviour
// - Shared core registers answer at the same offset in every data-memory bank.
// - Upper counter bits are hidden; a five-bit latch loads them on counter writes.
// - Power-on or brown-out reset and the other resets load separate values into the core registers.
// - Without ports D and E their registers are absent and read zero.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "bk1_defs.svh"
module bk1_sfr_bank #(
	parameter bit HAS_PORT_DE = 1'b1,
	parameter int ADDR_W = 11
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic extResetPin_n,
	input wire logic brownOutPin,
	input wire logic watchdogTimeout,
	input wire logic pcStep,
	input wire bk1_pkg::bk1_periph_in_t periphIn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	output var bk1_pkg::bk1_regs_t regsOut
);
	import bk1_pkg::*;

	generate
		if (ADDR_W < 11) begin : g_bad_addr
			$error("bk1_sfr_bank needs 11 address bits to reach all four banks");
		end
	endgenerate

	bk1_regs_t regs_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic [1:0] pinSync;
	logic powerClassRst;
	logic otherClassRst;
	logic [8:0] busIndex;
	logic [8:0] ptrIndex;
	bk1_sel_t busSel;
	bk1_sel_t ptrSel;
	bk1_sel_t wrSel;
	logic wrEn;
	logic [7:0] wrData;

	bk1_pin_sync #(
		.WIDTH(2),
		.RST_VAL(2'b10)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.pinIn({extResetPin_n, brownOutPin}),
		.pinOut(pinSync)
	);

	// Brown-out belongs to the power-on class; the pin and the watchdog are the other class.
	assign powerClassRst = pinSync[0];
	assign otherClassRst = !pinSync[1] || watchdogTimeout;

	function automatic bk1_sel_t decodeSel(input logic [8:0] idx);
		bk1_sel_t sel;
		sel = SEL_NONE;
		if (idx[6:0] == 7'(`BK1_OFS_INDIRECT)) begin
			sel = SEL_INDIRECT;
		end else if (idx[6:0] == 7'(`BK1_OFS_PC_LOW)) begin
			sel = SEL_PC_LOW;
		end else if (idx[6:0] == 7'(`BK1_OFS_STATUS)) begin
			sel = SEL_STATUS;
		end else if (idx[6:0] == 7'(`BK1_OFS_POINTER)) begin
			sel = SEL_POINTER;
		end else if (idx[6:0] == 7'(`BK1_OFS_PC_LATCH)) begin
			sel = SEL_PC_LATCH;
		end else if (idx[6:0] == 7'(`BK1_OFS_INT_CTRL)) begin
			sel = SEL_INT_CTRL;
		end else if (idx == 9'(`BK1_OFS_OPTIONS)) begin
			sel = SEL_OPTIONS;
		end else if (idx == 9'(`BK1_OFS_DIR_A)) begin
			sel = SEL_DIR_A;
		end else if (idx == 9'(`BK1_OFS_DIR_B)) begin
			sel = SEL_DIR_B;
		end else if (idx == 9'(`BK1_OFS_DIR_C)) begin
			sel = SEL_DIR_C;
		end else if (idx == 9'(`BK1_OFS_DIR_D) && HAS_PORT_DE) begin
			sel = SEL_DIR_D;
		end else if (idx == 9'(`BK1_OFS_DIR_E) && HAS_PORT_DE) begin
			sel = SEL_DIR_E;
		end else if (idx == 9'(`BK1_OFS_PERIPH_EN1)) begin
			sel = SEL_PERIPH_EN1;
		end else if (idx == 9'(`BK1_OFS_PERIPH_EN2)) begin
			sel = SEL_PERIPH_EN2;
		end else if (idx == 9'(`BK1_OFS_RESET_CAUSE)) begin
			sel = SEL_RESET_CAUSE;
		end else if (idx == 9'(`BK1_OFS_T2_PERIOD)) begin
			sel = SEL_T2_PERIOD;
		end else if (idx == 9'(`BK1_OFS_SER_ADDR)) begin
			sel = SEL_SER_ADDR;
		end else if (idx == 9'(`BK1_OFS_SER_STATUS)) begin
			sel = SEL_SER_STATUS;
		end else if (idx == 9'(`BK1_OFS_TX_CTRL)) begin
			sel = SEL_TX_CTRL;
		end else if (idx == 9'(`BK1_OFS_BAUD_DIV)) begin
			sel = SEL_BAUD_DIV;
		end
		return sel;
	endfunction

	// Peripheral status inputs (port full flags, serial flags, shift-empty) are merged in at read time, so reads show live state.
	function automatic logic [7:0] readSel(input bk1_sel_t sel, input bk1_regs_t r);
		logic [7:0] val;
		val = 8'h00;
		case (sel)
			SEL_OPTIONS: val = r.optionsReg;
			SEL_PC_LOW: val = r.programCounter[7:0];
			SEL_STATUS: val = r.statusReg;
			SEL_POINTER: val = r.pointer;
			SEL_DIR_A: val = r.dirA;
			SEL_DIR_B: val = r.dirB;
			SEL_DIR_C: val = r.dirC;
			SEL_DIR_D: val = r.dirD;
			SEL_DIR_E: val = {periphIn.pspInFull, periphIn.pspOutFull, r.dirE[5:4], 1'b0,
				r.dirE[2:0]};
			SEL_PC_LATCH: val = {3'h0, r.pcLatch};
			SEL_INT_CTRL: val = r.intCtrl;
			SEL_PERIPH_EN1: val = r.periphEn1;
			SEL_PERIPH_EN2: val = {7'h00, r.periphEn2};
			SEL_RESET_CAUSE: val = {6'h00, r.resetCause};
			SEL_T2_PERIOD: val = r.t2Period;
			SEL_SER_ADDR: val = r.serAddr;
			SEL_SER_STATUS: val = {r.serStatus[7:6], periphIn.serFlags};
			SEL_TX_CTRL: val = {r.txCtrl[7:4], 1'b0, r.txCtrl[2], periphIn.txShiftEmpty,
				r.txCtrl[0]};
			SEL_BAUD_DIV: val = r.baudDiv;
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	// A word index reaches all four banks; the pointer reaches all four banks through its bank bit.
	assign busIndex = paddr[10:2];
	assign ptrIndex = {regs_ff.statusReg[`BK1_STATUS_IRP], regs_ff.pointer};
	assign busSel = decodeSel(busIndex);

	// Indirect access through the indirect port itself finds nothing and reads zero.
	always_comb begin
		ptrSel = decodeSel(ptrIndex);
		if (ptrSel == SEL_INDIRECT) begin
			ptrSel = SEL_NONE;
		end
	end

	assign wrSel = (busSel == SEL_INDIRECT) ? ptrSel : busSel;
	assign wrEn = psel && penable && pready_ff && pwrite && pstrb[0] && (wrSel != SEL_NONE);
	assign wrData = pwdata[7:0];

	// Zero-wait APB: data is captured in the setup cycle and pready rises for the access phase.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
		end else if (clkEn) begin
			pready_ff <= psel && !penable;
			if (psel && !penable && !pwrite) begin
				prdata_ff <= {24'h00_0000, readSel(wrSel, regs_ff)};
			end
		end
	end

	// Core registers mirrored into every bank.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			regs_ff.statusReg <= `BK1_RST_STATUS_POR;
			regs_ff.pointer <= `BK1_RST_ZERO;
			regs_ff.pcLatch <= 5'h00;
			regs_ff.intCtrl <= `BK1_RST_ZERO;
			regs_ff.programCounter <= 13'h0000;
		end else if (clkEn) begin
			if (powerClassRst) begin
				regs_ff.statusReg <= `BK1_RST_STATUS_POR;
				regs_ff.pointer <= `BK1_RST_ZERO;
				regs_ff.pcLatch <= 5'h00;
				regs_ff.intCtrl <= `BK1_RST_ZERO;
				regs_ff.programCounter <= 13'h0000;
			end else if (otherClassRst) begin
				// Timeout clears the time-out flag; low bits and the pointer keep their value.
				regs_ff.statusReg[7:5] <= 3'h0;
				regs_ff.statusReg[`BK1_STATUS_TO] <= !watchdogTimeout;
				regs_ff.statusReg[`BK1_STATUS_PD] <= 1'b1;
				regs_ff.pcLatch <= 5'h00;
				regs_ff.intCtrl[7:1] <= 7'h00;
				regs_ff.programCounter <= 13'h0000;
			end else begin
				if (wrEn && wrSel == SEL_STATUS) begin
					regs_ff.statusReg[7:5] <= wrData[7:5];
					regs_ff.statusReg[2:0] <= wrData[2:0];
				end
				if (wrEn && wrSel == SEL_POINTER) begin
					regs_ff.pointer <= wrData;
				end
				if (wrEn && wrSel == SEL_PC_LATCH) begin
					regs_ff.pcLatch <= wrData[4:0];
				end
				if (wrEn && wrSel == SEL_INT_CTRL) begin
					regs_ff.intCtrl <= wrData;
				end
				// A low-byte write loads the whole counter, taking the top from the latch.
				if (wrEn && wrSel == SEL_PC_LOW) begin
					regs_ff.programCounter <= {regs_ff.pcLatch, wrData};
				end else if (pcStep) begin
					regs_ff.programCounter <= regs_ff.programCounter + 13'h0001;
				end
			end
		end
	end

	// Peripheral configuration registers; both reset classes load the same values here.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			regs_ff.optionsReg <= `BK1_RST_OPTIONS;
			regs_ff.dirA <= `BK1_RST_DIR_A;
			regs_ff.dirB <= `BK1_RST_DIR_FULL;
			regs_ff.dirC <= `BK1_RST_DIR_FULL;
			regs_ff.dirD <= `BK1_RST_DIR_FULL;
			regs_ff.periphEn1 <= `BK1_RST_ZERO;
			regs_ff.periphEn2 <= 1'b0;
			regs_ff.t2Period <= `BK1_RST_T2_PERIOD;
			regs_ff.serAddr <= `BK1_RST_ZERO;
			regs_ff.serStatus <= `BK1_RST_ZERO;
			regs_ff.txCtrl <= `BK1_RST_TX_CTRL;
			regs_ff.baudDiv <= `BK1_RST_ZERO;
		end else if (clkEn) begin
			if (powerClassRst || otherClassRst) begin
				regs_ff.optionsReg <= `BK1_RST_OPTIONS;
				regs_ff.dirA <= `BK1_RST_DIR_A;
				regs_ff.dirB <= `BK1_RST_DIR_FULL;
				regs_ff.dirC <= `BK1_RST_DIR_FULL;
				regs_ff.dirD <= `BK1_RST_DIR_FULL;
				regs_ff.periphEn1 <= `BK1_RST_ZERO;
				regs_ff.periphEn2 <= 1'b0;
				regs_ff.t2Period <= `BK1_RST_T2_PERIOD;
				regs_ff.serAddr <= `BK1_RST_ZERO;
				regs_ff.serStatus <= `BK1_RST_ZERO;
				regs_ff.txCtrl <= `BK1_RST_TX_CTRL;
				regs_ff.baudDiv <= `BK1_RST_ZERO;
			end else if (wrEn) begin
				case (wrSel)
					SEL_OPTIONS: regs_ff.optionsReg <= wrData;
					SEL_DIR_A: regs_ff.dirA <= {2'b00, wrData[5:0]};
					SEL_DIR_B: regs_ff.dirB <= wrData;
					SEL_DIR_C: regs_ff.dirC <= wrData;
					SEL_DIR_D: regs_ff.dirD <= wrData;
					// Reserved enable bits are stored as written; keeping them clear is software's part.
					SEL_PERIPH_EN1: regs_ff.periphEn1 <= wrData;
					SEL_PERIPH_EN2: regs_ff.periphEn2 <= wrData[0];
					SEL_T2_PERIOD: regs_ff.t2Period <= wrData;
					SEL_SER_ADDR: regs_ff.serAddr <= wrData;
					SEL_SER_STATUS: regs_ff.serStatus <= {wrData[7:6], 6'h00};
					SEL_TX_CTRL: regs_ff.txCtrl <= {wrData[7:4], 1'b0, wrData[2], 1'b1, wrData[0]};
					SEL_BAUD_DIV: regs_ff.baudDiv <= wrData;
					default: regs_ff.optionsReg <= regs_ff.optionsReg;
				endcase
			end
		end
	end

	// Port E direction and parallel-port flags; the overflow flag is sticky and set beats clear.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			regs_ff.dirE <= `BK1_RST_DIR_E;
		end else if (clkEn) begin
			if (powerClassRst || otherClassRst) begin
				regs_ff.dirE <= `BK1_RST_DIR_E;
			end else begin
				if (wrEn && wrSel == SEL_DIR_E) begin
					regs_ff.dirE[4] <= wrData[4];
					regs_ff.dirE[2:0] <= wrData[2:0];
				end
				regs_ff.dirE[7:6] <= {periphIn.pspInFull, periphIn.pspOutFull};
				regs_ff.dirE[3] <= 1'b0;
				if (HAS_PORT_DE && periphIn.pspOverflow) begin
					regs_ff.dirE[`BK1_DIRE_IBOV] <= 1'b1;
				end else if (wrEn && wrSel == SEL_DIR_E) begin
					regs_ff.dirE[`BK1_DIRE_IBOV] <= wrData[`BK1_DIRE_IBOV];
				end
			end
		end
	end

	// Reset-cause flags: only power-class resets touch them; software sets them again.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			regs_ff.resetCause <= `BK1_RST_CAUSE_POR;
		end else if (clkEn) begin
			if (powerClassRst) begin
				regs_ff.resetCause[0] <= 1'b0;
			end else if (!otherClassRst && wrEn && wrSel == SEL_RESET_CAUSE) begin
				regs_ff.resetCause <= wrData[1:0];
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = 1'b0;
	assign regsOut = regs_ff;
endmodule // bk1_sfr_bank
`default_nettype wire

// ### bk1_defs.svh
// Register indices, field positions and reset values of the bank-one register map.
`ifndef BK1_DEFS_SVH
`define BK1_DEFS_SVH

`define BK1_OFS_INDIRECT 8'h80
`define BK1_OFS_OPTIONS 8'h81
`define BK1_OFS_PC_LOW 8'h82
`define BK1_OFS_STATUS 8'h83
`define BK1_OFS_POINTER 8'h84
`define BK1_OFS_DIR_A 8'h85
`define BK1_OFS_DIR_B 8'h86
`define BK1_OFS_DIR_C 8'h87
`define BK1_OFS_DIR_D 8'h88
`define BK1_OFS_DIR_E 8'h89
`define BK1_OFS_PC_LATCH 8'h8a
`define BK1_OFS_INT_CTRL 8'h8b
`define BK1_OFS_PERIPH_EN1 8'h8c
`define BK1_OFS_PERIPH_EN2 8'h8d
`define BK1_OFS_RESET_CAUSE 8'h8e
`define BK1_OFS_T2_PERIOD 8'h92
`define BK1_OFS_SER_ADDR 8'h93
`define BK1_OFS_SER_STATUS 8'h94
`define BK1_OFS_TX_CTRL 8'h98
`define BK1_OFS_BAUD_DIV 8'h99

`define BK1_STATUS_IRP 7
`define BK1_STATUS_TO 4
`define BK1_STATUS_PD 3
`define BK1_DIRE_IBF 7
`define BK1_DIRE_OBF 6
`define BK1_DIRE_IBOV 5
`define BK1_TX_TRMT 1

`define BK1_RST_ZERO 8'h00
`define BK1_RST_OPTIONS 8'hff
`define BK1_RST_STATUS_POR 8'h18
`define BK1_RST_DIR_A 8'h3f
`define BK1_RST_DIR_FULL 8'hff
`define BK1_RST_DIR_E 8'h07
`define BK1_RST_T2_PERIOD 8'hff
`define BK1_RST_TX_CTRL 8'h02
`define BK1_RST_CAUSE_POR 2'b01

`endif

// ### bk1_pkg.sv
// Types shared by the bank-one register map and its users.
package bk1_pkg;

	typedef enum logic [4:0] {
		SEL_NONE, SEL_INDIRECT, SEL_OPTIONS, SEL_PC_LOW, SEL_STATUS, SEL_POINTER,
		SEL_DIR_A, SEL_DIR_B, SEL_DIR_C, SEL_DIR_D, SEL_DIR_E, SEL_PC_LATCH,
		SEL_INT_CTRL, SEL_PERIPH_EN1, SEL_PERIPH_EN2, SEL_RESET_CAUSE,
		SEL_T2_PERIOD, SEL_SER_ADDR, SEL_SER_STATUS, SEL_TX_CTRL, SEL_BAUD_DIV
	} bk1_sel_t;

	typedef struct packed {
		logic [7:0] optionsReg;
		logic [7:0] statusReg;
		logic [7:0] pointer;
		logic [7:0] dirA;
		logic [7:0] dirB;
		logic [7:0] dirC;
		logic [7:0] dirD;
		logic [7:0] dirE;
		logic [4:0] pcLatch;
		logic [7:0] intCtrl;
		logic [7:0] periphEn1;
		logic periphEn2;
		logic [1:0] resetCause;
		logic [7:0] t2Period;
		logic [7:0] serAddr;
		logic [7:0] serStatus;
		logic [7:0] txCtrl;
		logic [7:0] baudDiv;
		logic [12:0] programCounter;
	} bk1_regs_t;

	typedef struct packed {
		logic pspInFull;
		logic pspOutFull;
		logic pspOverflow;
		logic [5:0] serFlags;
		logic txShiftEmpty;
	} bk1_periph_in_t;

endpackage

// ### bk1_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/10ps
`default_nettype none
module bk1_pin_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [WIDTH-1:0] pinIn,
	output var logic [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] out_ff;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("bk1_pin_sync needs at least one bit");
		end
	endgenerate

	// The first stage feeds only the second, so no logic sees a metastable value.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
			stage3_ff <= RST_VAL;
		end else if (clkEn) begin
			stage1_ff <= pinIn;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_agree
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					out_ff[i] <= RST_VAL[i];
				end else if (clkEn && (stage2_ff[i] == stage3_ff[i])) begin
					out_ff[i] <= stage3_ff[i];
				end
			end
		end
	endgenerate

	assign pinOut = out_ff;
endmodule // bk1_pin_sync
`default_nettype wire

// ### bk1_sfr_bank_sva.sv
// Concurrent checks on the ports of the bank-one register map.
`timescale 1ns/10ps
`default_nettype none
module bk1_sfr_bank_sva #(
	parameter int ADDR_W = 11
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic extResetPin_n,
	input wire logic brownOutPin,
	input wire logic watchdogTimeout,
	input wire logic pcStep,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire bk1_pkg::bk1_regs_t regsOut
);
	import bk1_pkg::*;
	logic pcWr;
	logic quiet;
	logic rdSetup;
	// Raw pin levels only approximate the synchronised reset classes, so the bench keeps gaps.
	assign quiet = clkEn && extResetPin_n && !brownOutPin && !watchdogTimeout;
	assign pcWr = psel && penable && pready && pwrite && pstrb[0] && paddr[8:2] == 7'h02;
	assign rdSetup = psel && !penable && !pwrite && clkEn;
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_ready_setup: assert property (psel && !penable && clkEn |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready && clkEn |=> !pready)
		else $error("answer longer than one cycle");
	a_no_slverr: assert property (psel && penable && pready |-> !pslverr)
		else $error("error response given");
	a_read_upper: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_power_values: assert property ($fell(sys_rst) |-> regsOut.optionsReg == 8'hff
		&& regsOut.statusReg == 8'h18 && regsOut.dirA == 8'h3f && regsOut.t2Period == 8'hff
		&& regsOut.resetCause == 2'b01) else $error("power values wrong");
	a_wdog_status: assert property (watchdogTimeout && clkEn |-> ##[1:2]
		regsOut.statusReg[4:3] == 2'b01) else $error("timeout flags wrong");
	a_pc_step: assert property (pcStep && quiet && !pcWr |=>
		regsOut.programCounter == $past(regsOut.programCounter) + 13'h1)
		else $error("counter did not step");
	a_pc_load: assert property (pcWr && quiet |=>
		regsOut.programCounter == {$past(regsOut.pcLatch), $past(pwdata[7:0])})
		else $error("counter load wrong");
	a_latch_read: assert property (rdSetup && paddr[8:2] == 7'h0a |=>
		prdata == {27'h0, $past(regsOut.pcLatch)}) else $error("latch read wrong");
	a_unmapped_zero: assert property (rdSetup && paddr[10:2] == 9'h08f |=>
		prdata == 32'h0) else $error("hole read not zero");
endmodule // bk1_sfr_bank_sva
bind bk1_sfr_bank bk1_sfr_bank_sva #(.ADDR_W(ADDR_W)) u_sva (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .clkEn(clkEn), .extResetPin_n(extResetPin_n),
	.brownOutPin(brownOutPin), .watchdogTimeout(watchdogTimeout), .pcStep(pcStep),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .regsOut(regsOut));
`default_nettype wire

// ### bk1_sfr_bank_tb.sv
// Self-checking bench for the bank-one register map.
`timescale 1ns/10ps
`default_nettype none
module bk1_sfr_bank_tb;
	import bk1_pkg::*;
	logic clk_sys, sys_rst, clkEn, extResetPin_n, brownOutPin, watchdogTimeout, pcStep;
	logic psel, penable, pwrite, pready, pslverr, preadyB, pslverrB;
	logic [10:0] paddr;
	logic [31:0] pwdata, prdata, prdataB, rdB;
	logic [3:0] pstrb;
	bk1_periph_in_t periphIn;
	bk1_regs_t regsOut;
	int err_total = 0;
	int checked = 0;
	logic [8:0] idxT [20] = '{9'h080, 9'h081, 9'h082, 9'h083, 9'h084, 9'h085, 9'h086,
		9'h087, 9'h088, 9'h089, 9'h08a, 9'h08b, 9'h08c, 9'h08d, 9'h08e, 9'h092, 9'h093,
		9'h094, 9'h098, 9'h099};
	logic [7:0] rstT [20] = '{8'h00, 8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff, 8'hff,
		8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'h00, 8'h02, 8'h00};

	bk1_sfr_bank i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
		.extResetPin_n(extResetPin_n), .brownOutPin(brownOutPin),
		.watchdogTimeout(watchdogTimeout), .pcStep(pcStep), .periphIn(periphIn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .regsOut(regsOut));
	// Variant without ports D and E shares the bus; its read data, ready and error outputs are watched.
	bk1_sfr_bank #(.HAS_PORT_DE(1'b0)) i_dut_nopde (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.clkEn(clkEn), .extResetPin_n(extResetPin_n), .brownOutPin(brownOutPin),
		.watchdogTimeout(watchdogTimeout), .pcStep(pcStep), .periphIn(periphIn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdataB), .pready(preadyB), .pslverr(pslverrB), .regsOut());

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; leaves one idle cycle so strobes never reassert at once.
	task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] wd,
		input logic [3:0] st, output logic [31:0] rd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		pstrb <= st;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Wait for the answer however long it takes; the watchdog ends a hang.
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		// Zero-wait slave: the answer stands in the first access cycle, with no error.
		chk(n, 32'h0000_0001);
		chk({29'h0, preadyB, pslverrB, pslverr}, 32'h0000_0004);
		rd = prdata;
		rdB = prdataB;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, idx, d, 4'hf, r);
	endtask

	task automatic rd(input logic [8:0] idx, input logic [7:0] e);
		logic [31:0] r;
		apb(1'b0, idx, 8'h00, 4'h0, r);
		chk(r, {24'h0, e});
	endtask

	task automatic t_reset_vals();
		for (int i = 0; i < 20; i++) begin
			rd(idxT[i], rstT[i]);
		end
	endtask

	task automatic t_unmapped();
		logic [8:0] holes [10] = '{9'h08f, 9'h090, 9'h091, 9'h095, 9'h096, 9'h097,
			9'h09a, 9'h09b, 9'h09e, 9'h09f};
		foreach (holes[i]) begin
			wr(holes[i], 8'ha5);
			rd(holes[i], 8'h00);
		end
		t_reset_vals();
	endtask

	task automatic t_absent();
		rd(9'h088, 8'hff);
		chk(rdB, 32'h0);
		wr(9'h089, 8'h03);
		rd(9'h089, 8'h03);
		chk(rdB, 32'h0);
	endtask

	task automatic t_rw();
		logic [31:0] r;
		logic [8:0] a [10] = '{9'h081, 9'h092, 9'h093, 9'h099, 9'h08c, 9'h08d, 9'h085,
			9'h089, 9'h098, 9'h094};
		// Software keeps the reserved enable-one bits 7 and 6 clear on both variants.
		logic [7:0] d [10] = '{8'h5a, 8'h3c, 8'h81, 8'h7e, 8'h3f, 8'hff, 8'hff, 8'hd7,
			8'hff, 8'hff};
		logic [7:0] e [10] = '{8'h5a, 8'h3c, 8'h81, 8'h7e, 8'h3f, 8'h01, 8'h3f, 8'h17,
			8'hf7, 8'hc0};
		foreach (a[i]) begin
			wr(a[i], d[i]);
			rd(a[i], e[i]);
		end
		apb(1'b1, 9'h081, 8'h00, 4'h0, r);
		rd(9'h081, 8'h5a);
	endtask

	task automatic t_shared();
		wr(9'h184, 8'h81);
		rd(9'h004, 8'h81);
		rd(9'h100, 8'h5a);
		wr(9'h08b, 8'h3d);
		rd(9'h18b, 8'h3d);
	endtask

	task automatic t_pc();
		wr(9'h10a, 8'hff);
		rd(9'h08a, 8'h1f);
		wr(9'h182, 8'h34);
		chk({19'h0, regsOut.programCounter}, 32'h1f34);
		pcStep <= 1'b1;
		@(posedge clk_sys);
		pcStep <= 1'b0;
		@(posedge clk_sys);
		rd(9'h002, 8'h35);
		chk({19'h0, regsOut.programCounter}, 32'h1f35);
	endtask

	task automatic t_psp();
		periphIn.pspInFull <= 1'b1;
		periphIn.pspOverflow <= 1'b1;
		periphIn.serFlags <= 6'h2a;
		@(posedge clk_sys);
		periphIn.pspOverflow <= 1'b0;
		@(posedge clk_sys);
		rd(9'h089, 8'hb7);
		rd(9'h094, 8'hea);
		wr(9'h089, 8'h17);
		rd(9'h089, 8'h97);
		periphIn.pspInFull <= 1'b0;
	endtask

	task automatic t_wdog();
		watchdogTimeout <= 1'b1;
		@(posedge clk_sys);
		watchdogTimeout <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(9'h083, 8'h08);
		rd(9'h084, 8'h81);
		rd(9'h081, 8'hff);
		rd(9'h08b, 8'h01);
		rd(9'h08a, 8'h00);
		rd(9'h08e, 8'h01);
	endtask

	task automatic t_pins();
		extResetPin_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		extResetPin_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(9'h083, 8'h18);
		rd(9'h084, 8'h81);
		rd(9'h093, 8'h00);
		brownOutPin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		brownOutPin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd(9'h08e, 8'h00);
		rd(9'h084, 8'h00);
	endtask

	// With the enable low, neither a counter step nor a timeout may change any state.
	task automatic t_freeze();
		clkEn <= 1'b0;
		pcStep <= 1'b1;
		watchdogTimeout <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({19'h0, regsOut.programCounter}, 32'h0000_0000);
		chk({24'h0, regsOut.statusReg}, 32'h0000_0018);
		clkEn <= 1'b1;
		pcStep <= 1'b0;
		watchdogTimeout <= 1'b0;
		@(posedge clk_sys);
		rd(9'h083, 8'h18);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		end_sim();
	end

	initial begin
		sys_rst = 1'b1;
		clkEn = 1'b1;
		extResetPin_n = 1'b1;
		brownOutPin = 1'b0;
		watchdogTimeout = 1'b0;
		pcStep = 1'b0;
		periphIn = '0;
		periphIn.txShiftEmpty = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		t_reset_vals();
		t_unmapped();
		t_absent();
		t_rw();
		t_shared();
		t_pc();
		t_psp();
		t_wdog();
		t_pins();
		t_freeze();
		end_sim();
	end
endmodule // bk1_sfr_bank_tb
`default_nettype wire
